// ### core/sra_deser.sv
// Serial-to-parallel window and comma detector.
// Assumes bit_stb is a one-cycle pulse per received bit, same clock.
module sra_deser
	import sra_pkg::*;
(
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	input  wire logic                  bit_stb,
	input  wire logic                  bit_in,
	output logic      [SRA_W-1:0]      win,
	output logic                       win_stb,
	output logic                       comma
);

	// ****************************************
	// Window shift and detect
	// ****************************************
	logic [SRA_W-1:0] win_q, win_d;
	logic             stb_q, comma_q, comma_d;

	always_comb begin
		win_d   = win_q;
		if (bit_stb) begin
			// Newest bit enters at the top, so bit 0 is the earliest
			win_d = {bit_in, win_q[SRA_W-1:1]};
		end
		comma_d = bit_stb && (win_d[$bits(SRA_COMMA)-1:0] == SRA_COMMA); // R8
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			win_q   <= '0;
			stb_q   <= 1'b0;
			comma_q <= 1'b0;
		end else begin
			win_q   <= win_d;
			stb_q   <= bit_stb;
			comma_q <= comma_d;
		end
	end

	assign win     = win_q;
	assign win_stb = stb_q;
	assign comma   = comma_q;

endmodule // sra_deser

// ### core/sra_pkg.sv
// Constants, field layouts and mode types of the receive alignment block.
// Assumes a single 100 MHz core clock domain for all users.
package sra_pkg;

	// ****************************************
	// Word framing
	// ****************************************
	localparam int         SRA_W        = 10;
	localparam int         SRA_HW       = 5;
	localparam logic [3:0] SRA_LAST_BIT = 4'h9;
	localparam logic [3:0] SRA_MID_BIT  = 4'h4;
	localparam logic [3:0] SRA_ONE      = 4'h1;
	localparam logic [3:0] SRA_ZERO4    = 4'h0;
	// Comma prefix 0011111, earliest bit in bit 0
	localparam logic [6:0] SRA_COMMA    = 7'h7c;
	// Checker polynomial x^7 + x^6 + 1 over the newest bit
	localparam int         SRA_TAP_A    = 2;
	localparam int         SRA_TAP_B    = 3;

	// ****************************************
	// Signal detect thresholds in mV
	// ****************************************
	localparam logic [9:0] SRA_SIG_ON   = 10'h096;
	localparam logic [9:0] SRA_SIG_OFF  = 10'h032;

	// ****************************************
	// Register map and event bits
	// ****************************************
	localparam logic [3:0] SRA_A_STAT   = 4'h0;
	localparam logic [3:0] SRA_A_CLR    = 4'h4;
	localparam logic [3:0] SRA_A_EN     = 4'h8;
	localparam logic [3:0] SRA_A_CFG    = 4'hc;
	localparam int         SRA_EV_N     = 4;
	localparam int         SRA_CFG_N    = 5;
	localparam logic [3:0] SRA_EN_RST   = 4'h0;
	localparam int         SRA_EV_COMMA = 0;
	localparam int         SRA_EV_PERR  = 1;
	localparam int         SRA_EV_LOSS  = 2;
	localparam int         SRA_EV_REAL  = 3;

	typedef enum logic [2:0] {
		SRA_HALF = 3'h1,
		SRA_FULL = 3'h2,
		SRA_DDR  = 3'h4
	} sra_mode_e;

endpackage

// ### core/sra_top.sv
// Receive parallel output, byte clocks, comma alignment and status.
// Assumes mode pins are static pins with board pull-downs; the serial
// bit clock runs far below clk and is found by edge detection.
//
// Summary of operation
// R1: Width select low: ten-bit words on rx_data, bit 0 received first.
// R2: Width select high: upper five rx_data bits held low.
// R3: DDR mode: only clock A toggles at word rate, data on both edges.
// R4: Half-rate: clock B rises for words 0 and 2, clock A for 1 and 3.
// R5: Realignment only stretches byte clock periods, never shortens a phase.
// R6: Full-rate: only clock A runs at word rate, word on rising edge.
// R7: Half-rate only for width low and rate low; else clock B low.
// R8: With align enabled, find the comma and realign to it if needed.
// R9: With align disabled, no framing; words follow an arbitrary boundary.
// R10: Comma pulses on the status pin only while align is enabled.
// R11: With checker enabled, the status pin shows the pass result high.
// R12: Signal present above 150 mV, absent below 50 mV, held between.
// R13: Width select low picks ten bits; undriven defaults low.
// R14: Loopback routes transmit data to receiver and floats transmit outputs.
// R15: Controller keeps loopback low in normal operation.
// R16: DDR: bits 0 to 4 with rising edge, 5 to 9 with falling.
// R17: Checker errors drive the status pin low.
// R18: Half-rate clocks run at half word rate, offset by one word.
module sra_top
	import sra_pkg::*;
(
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	input  wire logic                  ser_clk,
	input  wire logic                  serial_in_pos,
	input  wire logic                  serial_in_neg,
	input  wire logic                  tx_serial_bit,
	input  wire logic [9:0]            rx_amp_mv,
	input  wire logic                  iface_width_sel,
	input  wire logic                  rx_clk_rate_sel,
	input  wire logic                  comma_align_en,
	input  wire logic                  prbs_test_en,
	input  wire logic                  internal_loop_en,
	input  wire logic [3:0]            reg_addr,
	input  wire logic [31:0]           reg_wdata,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	output logic      [31:0]           reg_rdata,
	output logic                       irq,
	output logic      [SRA_W-1:0]      rx_data,
	output logic                       rx_byte_clk_a,
	output logic                       rx_byte_clk_b,
	output logic                       comma_found_or_test_ok,
	output logic                       signal_present,
	output logic                       serial_out_pos,
	output logic                       serial_out_neg,
	output logic                       serial_out_oe_n
);

	// ****************************************
	// Mode decode
	// ****************************************
	function automatic sra_mode_e mode_of(input logic wsel, input logic rsel);
		if (wsel) begin
			return SRA_DDR;
		end else if (rsel) begin
			return SRA_FULL;
		end
		return SRA_HALF;
	endfunction

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [7:0] sy1_q, sy2_q, raw;
	logic       loop_s, pos_s, neg_s;

	assign loop_s = sy2_q[0];
	assign raw    = {ser_clk, serial_in_pos, serial_in_neg, iface_width_sel, rx_clk_rate_sel,
		comma_align_en, prbs_test_en, internal_loop_en};

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sy1_q <= '0;
			sy2_q <= '0;
		end else begin
			sy1_q <= raw;
			sy2_q <= sy1_q;
		end
	end

	logic sclk_s, sbit_s, wsel_s, rsel_s, align_s, prbs_s;
	assign {sclk_s, pos_s, neg_s, wsel_s, rsel_s, align_s, prbs_s} = sy2_q[7:1];
	// Transmit bit is already on clk, so loopback picks it after the pin flops
	assign sbit_s = loop_s ? tx_serial_bit : (pos_s & ~neg_s); // R14

	// ****************************************
	// Bit strobe and window
	// ****************************************
	logic             sclk_q, bit_stb;
	logic [SRA_W-1:0] win;
	logic             win_stb, comma;

	assign bit_stb = sclk_s & ~sclk_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sclk_q <= 1'b0;
		end else begin
			sclk_q <= sclk_s;
		end
	end

	sra_deser sra_deser_inst (
		.clk     (clk),
		.rst_n   (rst_n),
		.bit_stb (bit_stb),
		.bit_in  (sbit_s),
		.win     (win),
		.win_stb (win_stb),
		.comma   (comma)
	);

	// ****************************************
	// Framing, byte clocks and data
	// ****************************************
	sra_mode_e        mode_q, mode_d;
	logic [3:0]       cnt_q, cnt_d, nxt;
	logic [SRA_W-1:0] word_q, word_d, data_q, data_d;
	logic             par_q, par_d, ca_q, ca_d, cb_q, cb_d;
	logic             realign, word_ev, comma_hit;

	always_comb begin
		mode_d    = mode_of(wsel_s, rsel_s); // R7 R13
		nxt       = (cnt_q == SRA_LAST_BIT) ? SRA_ZERO4 : cnt_q + SRA_ONE;
		comma_hit = win_stb && align_s && comma; // R8 R10
		// Disabled alignment leaves the free-running count alone
		realign   = comma_hit && (nxt != SRA_LAST_BIT); // R8 R9
		// A misaligned word is dropped, so the period only grows
		word_ev   = win_stb && (nxt == SRA_LAST_BIT); // R5
		cnt_d     = cnt_q;
		if (win_stb) begin
			cnt_d = realign ? SRA_LAST_BIT : nxt;
		end
		word_d = word_q;
		data_d = data_q;
		par_d  = par_q;
		ca_d   = ca_q;
		cb_d   = 1'b0;
		case (mode_q)
			SRA_HALF: begin
				if (word_ev) begin
					data_d = win; // R1
					ca_d   = par_q; // R4
					par_d  = ~par_q; // R18
				end
				cb_d = ~ca_d; // R4 R18
			end
			SRA_FULL: begin
				par_d = 1'b0;
				if (word_ev) begin
					data_d = win; // R1 R6
					ca_d   = 1'b1; // R6
				end else if (win_stb && cnt_d == SRA_MID_BIT) begin
					ca_d = 1'b0; // R6
				end
			end
			SRA_DDR: begin
				par_d = 1'b0;
				if (word_ev) begin
					word_d = win;
					data_d = {{SRA_HW{1'b0}}, win[SRA_HW-1:0]}; // R2 R16
					ca_d   = 1'b1; // R3
				end else if (win_stb && cnt_d == SRA_MID_BIT) begin
					data_d = {{SRA_HW{1'b0}}, word_q[SRA_W-1:SRA_HW]}; // R2 R16
					ca_d   = 1'b0; // R3
				end else begin
					data_d = {{SRA_HW{1'b0}}, data_q[SRA_HW-1:0]}; // R2
				end
			end
			default: begin
				ca_d = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_q <= SRA_HALF;
			cnt_q  <= SRA_ZERO4;
			word_q <= '0;
			data_q <= '0;
			par_q  <= 1'b0;
			ca_q   <= 1'b0;
			cb_q   <= 1'b0;
		end else begin
			mode_q <= mode_d;
			cnt_q  <= cnt_d;
			word_q <= word_d;
			data_q <= data_d;
			par_q  <= par_d;
			ca_q   <= ca_d;
			cb_q   <= cb_d;
		end
	end

	// ****************************************
	// Sequence checker, status pin, detect
	// ****************************************
	logic       werr_q, werr_d, pass_q, pass_d, cf_q, cf_d;
	logic       sig_q, sig_d, bit_err, tx_q, oe_n_q, txn_q, txn_d;

	always_comb begin
		bit_err = win_stb && prbs_s &&
			(win[SRA_W-1] != (win[SRA_TAP_A] ^ win[SRA_TAP_B]));
		werr_d  = word_ev ? 1'b0 : (werr_q | bit_err);
		pass_d  = pass_q;
		if (bit_err) begin
			pass_d = 1'b0; // R17
		end else if (word_ev && !werr_q) begin
			pass_d = 1'b1; // R11
		end
		cf_d  = prbs_s ? pass_d : comma_hit; // R10 R11
		txn_d = ~tx_serial_bit;
		sig_d = sig_q;
		if (rx_amp_mv > SRA_SIG_ON) begin
			sig_d = 1'b1; // R12
		end else if (rx_amp_mv < SRA_SIG_OFF) begin
			sig_d = 1'b0; // R12
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			werr_q <= 1'b0;
			pass_q <= 1'b0;
			cf_q   <= 1'b0;
			sig_q  <= 1'b0;
			tx_q   <= 1'b0;
			txn_q  <= 1'b1;
			oe_n_q <= 1'b1;
		end else begin
			werr_q <= werr_d;
			pass_q <= pass_d;
			cf_q   <= cf_d;
			sig_q  <= sig_d;
			tx_q   <= tx_serial_bit;
			txn_q  <= txn_d;
			oe_n_q <= loop_s; // R14
		end
	end

	// ****************************************
	// Event registers and register port
	// ****************************************
	logic [SRA_EV_N-1:0] ev, stat_q, stat_d, en_q, en_d, clr;
	logic [31:0]         rd_q, rd_d;
	logic                irq_q, irq_d;

	always_comb begin
		ev               = '0;
		ev[SRA_EV_COMMA] = comma_hit;
		ev[SRA_EV_PERR]  = bit_err;
		ev[SRA_EV_LOSS]  = sig_q & ~sig_d;
		ev[SRA_EV_REAL]  = realign;
		clr    = (reg_wr && reg_addr == SRA_A_CLR) ? reg_wdata[SRA_EV_N-1:0] : '0;
		// A new event beats a clear in the same cycle
		stat_d = (stat_q & ~clr) | ev;
		en_d   = (reg_wr && reg_addr == SRA_A_EN) ? reg_wdata[SRA_EV_N-1:0] : en_q;
		irq_d  = |(stat_q & en_q);
		rd_d   = '0;
		if (reg_rd) begin
			case (reg_addr)
				SRA_A_STAT: rd_d[SRA_EV_N-1:0]  = stat_q;
				SRA_A_EN:   rd_d[SRA_EV_N-1:0]  = en_q;
				SRA_A_CFG:  rd_d[SRA_CFG_N-1:0] = {loop_s, prbs_s, align_s, rsel_s, wsel_s};
				default:    rd_d = '0;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stat_q <= '0;
			en_q   <= SRA_EN_RST;
			rd_q   <= '0;
			irq_q  <= 1'b0;
		end else begin
			stat_q <= stat_d;
			en_q   <= en_d;
			rd_q   <= rd_d;
			irq_q  <= irq_d;
		end
	end

	assign reg_rdata              = rd_q;
	assign irq                    = irq_q;
	assign rx_data                = data_q;
	assign rx_byte_clk_a          = ca_q;
	assign rx_byte_clk_b          = cb_q;
	assign comma_found_or_test_ok = cf_q;
	assign signal_present         = sig_q;
	assign serial_out_pos         = tx_q;
	assign serial_out_neg         = txn_q;
	assign serial_out_oe_n        = oe_n_q;

	// ****************************************
	// Checks
	// ****************************************
	// Bit strobes since clock B last moved, and a first-toggle guard
	logic [5:0] ph_q;
	logic       hseen_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ph_q    <= '0;
			hseen_q <= 1'b0;
		end else begin
			ph_q    <= (cb_d != cb_q) ? 6'h00 : (win_stb ? ph_q + 6'h01 : ph_q);
			hseen_q <= (mode_q == SRA_HALF) && (hseen_q || cb_d != cb_q);
		end
	end

	upper_low_a: assert property (@(posedge clk) disable iff (!rst_n) // R2
		($past(mode_q) == SRA_DDR) |-> (rx_data[9:5] == 5'h00))
		else $error("upper data bits not low in DDR mode");
	clkb_idle_a: assert property (@(posedge clk) disable iff (!rst_n) // R7
		($past(mode_q) != SRA_HALF) |-> !rx_byte_clk_b)
		else $error("clock B active outside half-rate mode");
	half_alt_a: assert property (@(posedge clk) disable iff (!rst_n) // R4
		($past(rst_n) && $past(mode_q) == SRA_HALF) |-> (rx_byte_clk_a != rx_byte_clk_b))
		else $error("half-rate clocks not in opposition");
	no_sliver_a: assert property (@(posedge clk) disable iff (!rst_n) // R5
		(hseen_q && (mode_q == SRA_HALF) && (cb_d != cb_q)) |-> (ph_q >= 6'h09))
		else $error("half-rate clock phase shortened");
	word_out_a: assert property (@(posedge clk) disable iff (!rst_n) // R6
		(mode_q == SRA_FULL && $past(mode_q) == SRA_FULL && word_ev)
		|=> (rx_data == $past(win)) && rx_byte_clk_a)
		else $error("full-rate word not presented with rising clock");
	comma_gate_a: assert property (@(posedge clk) disable iff (!rst_n) // R10
		(comma_found_or_test_ok && !$past(prbs_s)) |-> $past(align_s))
		else $error("comma pulse while alignment disabled");
	prbs_fail_a: assert property (@(posedge clk) disable iff (!rst_n) // R17
		(prbs_s && bit_err) |=> !comma_found_or_test_ok ##1 !pass_q)
		else $error("checker error not shown low");
	sig_on_a: assert property (@(posedge clk) disable iff (!rst_n) // R12
		(rx_amp_mv > SRA_SIG_ON) |=> signal_present)
		else $error("signal present not set above upper threshold");
	sig_off_a: assert property (@(posedge clk) disable iff (!rst_n) // R12
		(rx_amp_mv < SRA_SIG_OFF) |=> !signal_present)
		else $error("signal present not cleared below lower threshold");
	loop_hiz_a: assert property (@(posedge clk) disable iff (!rst_n) // R14
		loop_s |=> serial_out_oe_n)
		else $error("transmit outputs driven during loopback");
	sticky_set_a: assert property (@(posedge clk) disable iff (!rst_n) // R10
		comma_hit |=> stat_q[SRA_EV_COMMA] [*2])
		else $error("comma event not held in status");

endmodule // sra_top

// ### tb/sra_link_model.sv
// Far-end serial source: bit clock and differential receive data.
// Assumes the bench calls send_word just after a falling clk edge.
module sra_link_model (
	output logic ser_clk,
	output logic serial_in_pos,
	output logic serial_in_neg
);
	timeunit 1ns;
	timeprecision 100ps;

	// ****************************************
	// Bit stream
	// ****************************************
	initial begin
		ser_clk = 1'b0;
		serial_in_pos = 1'b0;
		serial_in_neg = 1'b1;
	end

	// Bit clock stands still between calls; data moves only while it is low
	task automatic send_word(input logic [9:0] w);
		for (int i = 0; i < 10; i++) begin
			serial_in_pos = w[i];
			serial_in_neg = ~w[i];
			#80 ser_clk = 1'b1;
			#80 ser_clk = 1'b0;
		end
		// Idle line shows the inverse so a stale bit cannot pass for data
		serial_in_pos = ~w[9];
		serial_in_neg = w[9];
	endtask
endmodule // sra_link_model

// ### tb/sra_top_bench.sv
// Self-checking bench for the receive alignment block.
// Assumes sra_link_model as far end; mode pins settle within ten clocks.
module sra_top_bench;
	timeunit 1ns;
	timeprecision 100ps;
	import sra_pkg::*;

	// ****************************************
	// Signals and instances
	// ****************************************
	logic        clk = 1'b0, rst_n = 1'b0, tx_serial_bit = 1'b0, reg_wr = 1'b0;
	logic        iface_width_sel = 1'b0, rx_clk_rate_sel = 1'b0, reg_rd = 1'b0;
	logic        comma_align_en = 1'b0, prbs_test_en = 1'b0, internal_loop_en = 1'b0;
	logic [9:0]  rx_amp_mv = 10'h000;
	logic [3:0]  reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0, reg_rdata;
	logic [9:0]  rx_data;
	logic        irq, rx_byte_clk_a, rx_byte_clk_b, comma_found_or_test_ok, signal_present;
	logic        serial_out_pos, serial_out_neg, serial_out_oe_n;
	logic        ser_clk, serial_in_pos, serial_in_neg;
	int          mismatches = 0, samples_checked = 0, ph = 0, min_ph = 9999, pulses = 0;
	logic        a_q = 1'b0, b_q = 1'b0, s_q = 1'b0, ph_ok = 1'b0;
	logic [9:0]  rise_q[$], fall_q[$];
	logic        which_q[$];
	logic [9:0]  wds [4] = '{10'h133, 10'h3b6, 10'h0cd, 10'h155};

	sra_top sra_top_inst (.clk, .rst_n, .ser_clk, .serial_in_pos, .serial_in_neg,
		.tx_serial_bit, .rx_amp_mv, .iface_width_sel, .rx_clk_rate_sel, .comma_align_en,
		.prbs_test_en, .internal_loop_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .irq, .rx_data, .rx_byte_clk_a, .rx_byte_clk_b,
		.comma_found_or_test_ok, .signal_present, .serial_out_pos, .serial_out_neg,
		.serial_out_oe_n);
	sra_link_model sra_link_model_inst (.ser_clk, .serial_in_pos, .serial_in_neg);

	always #5 clk = ~clk;

	// Byte clock edges, shortest phase and status pulses
	always @(posedge clk) begin
		ph++;
		if (rx_byte_clk_a !== a_q) begin
			if (ph_ok && ph < min_ph) min_ph = ph;
			ph_ok = 1'b1;
			ph = 0;
		end
		if (rx_byte_clk_a && !a_q) begin
			rise_q.push_back(rx_data);
			which_q.push_back(1'b0);
		end
		if (rx_byte_clk_b && !b_q) begin
			rise_q.push_back(rx_data);
			which_q.push_back(1'b1);
		end
		if (!rx_byte_clk_a && a_q) fall_q.push_back(rx_data);
		if (comma_found_or_test_ok && !s_q) pulses++;
		a_q = rx_byte_clk_a;
		b_q = rx_byte_clk_b;
		s_q = comma_found_or_test_ok;
	end

	// ****************************************
	// Tasks and scenarios
	// ****************************************
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [31:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask

	// Mode pins, one comma word, then a clean monitor
	task automatic prime(input logic w, input logic r, input logic al);
		@(posedge clk);
		iface_width_sel <= w;
		rx_clk_rate_sel <= r;
		comma_align_en <= al;
		repeat (10) @(posedge clk);
		@(negedge clk);
		pulses = 0;
		sra_link_model_inst.send_word(10'h17c);
		repeat (20) @(posedge clk);
		@(negedge clk);
		rise_q.delete();
		fall_q.delete();
		which_q.delete();
		ph_ok = 1'b0;
		min_ph = 9999;
	endtask

	// Four words back to back; the pad lets the last word's clock fall
	task automatic burst();
		@(negedge clk);
		for (int i = 0; i < 4; i++) sra_link_model_inst.send_word(wds[i]);
		sra_link_model_inst.send_word(10'h2aa);
		repeat (20) @(posedge clk);
	endtask

	task automatic t_full();
		prime(1'b0, 1'b1, 1'b1);
		chk("comma pulses", 1, pulses);
		burst();
		for (int i = 0; i < 4; i++) begin
			chk("full word", {22'h0, wds[i]}, {22'h0, rise_q[i]});
			chk("full clock b", 0, {31'h0, which_q[i]});
		end
		chk("full phase", 1, {31'h0, min_ph >= 80});
	endtask

	task automatic t_noalign();
		prime(1'b0, 1'b1, 1'b0);
		chk("unaligned pulses", 0, pulses);
	endtask

	task automatic t_half();
		prime(1'b0, 1'b0, 1'b1);
		burst();
		for (int i = 0; i < 4; i++) chk("half word", {22'h0, wds[i]}, {22'h0, rise_q[i]});
		for (int i = 0; i < 3; i++) chk("half alternate", 1, {31'h0, which_q[i] != which_q[i+1]});
		chk("half phase", 1, {31'h0, min_ph >= 160});
	endtask

	task automatic t_ddr();
		prime(1'b1, 1'b0, 1'b1);
		burst();
		for (int i = 0; i < 4; i++) begin
			chk("ddr rise", {27'h0, wds[i][4:0]}, {22'h0, rise_q[i]});
			// A word's falling edge comes five bits into the next word
			chk("ddr fall", {27'h0, wds[i][9:5]}, {22'h0, fall_q[i+1]});
			chk("ddr clock b", 0, {31'h0, which_q[i]});
		end
		chk("ddr phase", 1, {31'h0, min_ph >= 80});
	endtask

	task automatic t_prbs();
		logic       b [70];
		logic [9:0] w;
		for (int i = 0; i < 70; i++) b[i] = (i < 7) ? (i == 0) : b[i-7] ^ b[i-6];
		@(posedge clk);
		prbs_test_en <= 1'b1;
		comma_align_en <= 1'b0;
		repeat (10) @(posedge clk);
		for (int k = 0; k < 7; k++) begin
			for (int i = 0; i < 10; i++) w[i] = b[10*k+i] ^ (k == 6 && i == 9);
			@(negedge clk);
			sra_link_model_inst.send_word(w);
			repeat (5) @(posedge clk);
			if (k == 5) chk("prbs pass", 1, {31'h0, comma_found_or_test_ok});
		end
		chk("prbs error", 0, {31'h0, comma_found_or_test_ok});
		prbs_test_en <= 1'b0;
	endtask

	task automatic t_status();
		logic [31:0] d;
		logic [9:0]  amp [6] = '{10'h097, 10'h064, 10'h031, 10'h064, 10'h3ff, 10'h000};
		logic        exp [6] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
		for (int i = 0; i < 5; i++) begin
			@(posedge clk);
			rx_amp_mv <= amp[i];
			repeat (3) @(posedge clk);
			chk("signal present", {31'h0, exp[i]}, {31'h0, signal_present});
		end
		rd(SRA_A_EN, d);
		chk("enable reset", 0, d);
		rd(4'h2, d);
		chk("unmapped", 0, d);
		rd(SRA_A_CFG, d);
		chk("config", {27'h0, internal_loop_en, prbs_test_en, comma_align_en,
			rx_clk_rate_sel, iface_width_sel}, d);
		rd(SRA_A_STAT, d);
		chk("status", 3'h7, {29'h0, d[2:0]});
		wr(SRA_A_EN, 32'h4);
		repeat (3) @(posedge clk);
		chk("irq on", 1, {31'h0, irq});
		wr(SRA_A_EN, 32'h0);
		repeat (3) @(posedge clk);
		chk("irq masked", 0, {31'h0, irq});
		wr(SRA_A_CLR, 32'h4);
		wr(SRA_A_EN, 32'h4);
		repeat (3) @(posedge clk);
		chk("irq cleared", 0, {31'h0, irq});
		@(posedge clk);
		rx_amp_mv <= amp[5];
		repeat (4) @(posedge clk);
		chk("loss irq", 1, {31'h0, irq});
		wr(SRA_A_CLR, 32'h4);
		repeat (3) @(posedge clk);
		chk("irq cleared", 0, {31'h0, irq});
	endtask

	task automatic t_loop();
		@(posedge clk);
		tx_serial_bit <= 1'b1;
		repeat (3) @(posedge clk);
		chk("tx pos", 1, {31'h0, serial_out_pos});
		chk("tx neg", 0, {31'h0, serial_out_neg});
		chk("tx driven", 0, {31'h0, serial_out_oe_n});
		internal_loop_en <= 1'b1;
		repeat (6) @(posedge clk);
		chk("tx floated", 1, {31'h0, serial_out_oe_n});
		@(negedge clk);
		sra_link_model_inst.send_word(10'h000);
		repeat (5) @(posedge clk);
		chk("loop data", 32'h1f, {22'h0, rx_data});
		internal_loop_en <= 1'b0;
		repeat (6) @(posedge clk);
		chk("tx driven", 0, {31'h0, serial_out_oe_n});
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		t_full();
		t_noalign();
		t_half();
		t_ddr();
		t_prbs();
		t_status();
		t_loop();
		finish_test();
	end

	// Run needs about 46 us; a hang is cut well beyond that
	initial begin
		#400us;
		mismatches++;
		finish_test();
	end
endmodule // sra_top_bench
